// >>> src/tsd_consts.svh
// Purpose: constants for the transmit switched diversity controller
// Assumes: 100 MHz CLK, Avalon-MM word addressing by byte address
// Notes:   offsets are byte addresses of 32-bit registers
`ifndef TSD_CONSTS_SVH
`define TSD_CONSTS_SVH
`define TSD_OFS_CTRL        6'h00
`define TSD_OFS_PERIOD      6'h04
`define TSD_OFS_RATE_THR    6'h08
`define TSD_OFS_ACTIVE      6'h0C
`define TSD_OFS_STATUS      6'h10
`define TSD_OFS_CSI0        6'h20
`define TSD_CTRL_EN_BIT     0
`define TSD_CTRL_PRO_BIT    1
`define TSD_CTRL_BEGIN_BIT  2
`define TSD_PERIOD_RST      32'h000F4240
`define TSD_RATE_THR_RST    8'h10
`define TSD_RSP_TMO         16'h0400
`define TSD_DIV_STAT_BEGIN  2'h1
`define TSD_DIV_STAT_SCAN   2'h2
`define TSD_NUM_ANT         4
`define TSD_ANT_W           2
`endif

// >>> src/tsd_ctrl.sv
// Purpose: source-side transmit switched diversity control
// Assumes: single clock, peer keeps its own response and switch duties
// Notes:   Avalon-MM slave, one waitrequest-low cycle per access
//
// Overview of operation
// - Start diversity with a setup request marked begin on any antenna.
// - On a switch command requesting change, move to another antenna.
// - Initial active antenna is any antenna, set by software.
// - Proactive mode enters scan periodically to probe inactive antennas.
// - Scan only begins while no data transmission is in progress.
// - Scan steps antennas, sends scan request, stores returned state.
// - After a full scan choose the antenna with highest rate.
// - A rate drop from poor channel may trigger a reselection.
// - Below the rate threshold, keep rescanning periodically.
`include "tsd_consts.svh"
`default_nettype none
module tsd_ctrl
(
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic [5:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  output logic [31:0]           AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  input  wire logic             TX_BUSY,
  input  wire logic [7:0]       CUR_RATE,
  input  wire tsd_pkg::tsd_rsp_t RSP,
  input  wire tsd_pkg::tsd_sw_t  SW_CMD,
  output tsd_pkg::tsd_req_t     REQ,
  output tsd_pkg::tsd_ant_t     ACTIVE_ANT
);

  logic [2:0]          ctrl_reg;
  logic [31:0]         period_reg;
  logic [7:0]          rate_thr_reg;
  tsd_pkg::tsd_ant_t   active_reg;
  logic [7:0]          csi_reg [`TSD_NUM_ANT];
  logic                capable_reg;
  tsd_pkg::tsd_state_t state_reg;
  logic [31:0]         timer_reg;
  tsd_pkg::tsd_ant_t   scan_ant_reg;
  tsd_pkg::tsd_ant_t   best_ant_reg;
  logic [7:0]          best_rate_reg;
  logic [7:0]          last_rate_reg;
  logic                rate_drop_reg;
  logic                begin_req_reg;
  logic                ack_reg;
  logic                wr_ok;
  logic                rd_ok;
  logic [15:0]         wait_reg;
  logic                rsp_late;

  // Next antenna in round-robin order, used for switching and scanning
  function automatic tsd_pkg::tsd_ant_t next_ant(input tsd_pkg::tsd_ant_t a);
    next_ant = a + `TSD_ANT_W'(1);
  endfunction

  // An access is taken only in the cycle before its acknowledge, so a
  // request held through waitrequest is never counted twice
  assign wr_ok = AVS_WRITE && !ack_reg;
  assign rd_ok = AVS_READ && !ack_reg;

  // Waitrequest low for one cycle per access, high otherwise
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      ack_reg <= 1'b0;
    else
      ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
  end

  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_reg);
  end

  // Configuration registers written by software. The start bit clears
  // itself once the request is out, whatever other register the bus
  // writes that cycle, so a later re-enable cannot fire a stale start; a
  // write to the control word in that same cycle still wins.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_reg     <= 3'h0;
      period_reg   <= `TSD_PERIOD_RST;
      rate_thr_reg <= `TSD_RATE_THR_RST;
    end
    else
    begin
      if (begin_req_reg)
        ctrl_reg[`TSD_CTRL_BEGIN_BIT] <= 1'b0; // Self-clearing start
      if (wr_ok)
      begin
        case (AVS_ADDRESS)
          `TSD_OFS_CTRL:     ctrl_reg <= AVS_WRITEDATA[2:0];
          `TSD_OFS_PERIOD:   period_reg <= AVS_WRITEDATA;
          `TSD_OFS_RATE_THR: rate_thr_reg <= AVS_WRITEDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      AVS_READDATA <= 32'h0;
    else if (rd_ok)
    begin
      case (AVS_ADDRESS)
        `TSD_OFS_CTRL:     AVS_READDATA <= {29'h0, ctrl_reg};
        `TSD_OFS_PERIOD:   AVS_READDATA <= period_reg;
        `TSD_OFS_RATE_THR: AVS_READDATA <= {24'h0, rate_thr_reg};
        `TSD_OFS_ACTIVE:   AVS_READDATA <= {30'h0, active_reg};
        `TSD_OFS_STATUS:
          AVS_READDATA <= {26'h0, capable_reg, state_reg};
        `TSD_OFS_CSI0, `TSD_OFS_CSI0 + 6'h04,
        `TSD_OFS_CSI0 + 6'h08, `TSD_OFS_CSI0 + 6'h0C:
          AVS_READDATA <= {24'h0, csi_reg[AVS_ADDRESS[3:2]]};
        default:           AVS_READDATA <= 32'h0;
      endcase
    end
  end

  // Rate drop detector for event-driven reselection
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      last_rate_reg <= 8'h0;
      rate_drop_reg <= 1'b0;
    end
    else
    begin
      last_rate_reg <= CUR_RATE;
      if (CUR_RATE < last_rate_reg)
        rate_drop_reg <= 1'b1;
      else if (state_reg == tsd_pkg::ST_SCAN)
        rate_drop_reg <= 1'b0;
    end
  end

  // Scan period timer; only runs while the sequencer is in ST_RUN
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      timer_reg <= 32'h0;
    else if (state_reg != tsd_pkg::ST_RUN || timer_reg >= period_reg)
      timer_reg <= 32'h0;
    else
      timer_reg <= timer_reg + 32'h1;
  end

  // Answer watchdog: a peer that never responds must not park the
  // sequencer in setup or scan; restarts with every request sent
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || REQ.valid ||
        (state_reg != tsd_pkg::ST_SETUP && state_reg != tsd_pkg::ST_SCAN))
      wait_reg <= 16'h0;
    else if (!rsp_late)
      wait_reg <= wait_reg + 16'h1;
  end

  assign rsp_late = wait_reg >= `TSD_RSP_TMO; // Saturates, never wraps

  // Main sequencer: setup, run, scan and pick. It also owns the antenna
  // select, so the RF switch moves on the very edge a request leaves
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state_reg     <= tsd_pkg::ST_IDLE;
      active_reg    <= '0;
      scan_ant_reg  <= '0;
      best_ant_reg  <= '0;
      best_rate_reg <= 8'h0;
      capable_reg   <= 1'b0;
      begin_req_reg <= 1'b0;
      REQ           <= '0;
      ACTIVE_ANT    <= '0;
      for (int i = 0; i < `TSD_NUM_ANT; i++)
        csi_reg[i] <= 8'h0;
    end
    else
    begin
      REQ.valid     <= 1'b0;
      begin_req_reg <= 1'b0;
      case (state_reg)
        tsd_pkg::ST_IDLE:
        begin
          if (wr_ok && AVS_ADDRESS == `TSD_OFS_ACTIVE)
          begin
            active_reg <= AVS_WRITEDATA[`TSD_ANT_W-1:0];
            ACTIVE_ANT <= AVS_WRITEDATA[`TSD_ANT_W-1:0];
          end
          if (ctrl_reg[`TSD_CTRL_EN_BIT] &&
              ctrl_reg[`TSD_CTRL_BEGIN_BIT])
          begin
            REQ.valid     <= 1'b1;
            REQ.status    <= `TSD_DIV_STAT_BEGIN;
            REQ.antenna   <= active_reg;
            begin_req_reg <= 1'b1;
            state_reg     <= tsd_pkg::ST_SETUP;
          end
        end
        tsd_pkg::ST_SETUP:
        begin
          if (!ctrl_reg[`TSD_CTRL_EN_BIT])
            state_reg <= tsd_pkg::ST_IDLE;
          else if (RSP.valid)
          begin
            capable_reg <= RSP.capable;
            state_reg   <= RSP.capable ? tsd_pkg::ST_RUN
                                       : tsd_pkg::ST_IDLE;
          end
          else if (rsp_late)
            state_reg <= tsd_pkg::ST_IDLE; // Silent peer; software retries
        end
        tsd_pkg::ST_RUN:
        begin
          if (!ctrl_reg[`TSD_CTRL_EN_BIT])
            state_reg <= tsd_pkg::ST_IDLE;
          else if (SW_CMD.valid && SW_CMD.do_switch)
          begin
            // Unconditional: no metric is weighed on this side
            active_reg <= next_ant(active_reg);
            ACTIVE_ANT <= next_ant(active_reg);
          end
          else if (ctrl_reg[`TSD_CTRL_PRO_BIT] && !TX_BUSY &&
                   (timer_reg >= period_reg || rate_drop_reg ||
                    (CUR_RATE < rate_thr_reg &&
                     timer_reg >= period_reg)))
          begin
            scan_ant_reg  <= next_ant(active_reg);
            best_ant_reg  <= active_reg;
            best_rate_reg <= CUR_RATE;
            csi_reg[active_reg] <= CUR_RATE;
            REQ.valid     <= 1'b1;
            REQ.status    <= `TSD_DIV_STAT_SCAN;
            // Antenna moves with the request, so the probe leaves on it
            ACTIVE_ANT    <= next_ant(active_reg);
            REQ.antenna   <= next_ant(active_reg);
            state_reg     <= tsd_pkg::ST_SCAN;
          end
        end
        tsd_pkg::ST_SCAN:
        begin
          if (!ctrl_reg[`TSD_CTRL_EN_BIT])
          begin
            ACTIVE_ANT <= active_reg; // Leave the probe antenna at once
            state_reg  <= tsd_pkg::ST_IDLE;
          end
          else if (RSP.valid)
          begin
            csi_reg[scan_ant_reg] <= RSP.rate;
            if (RSP.rate > best_rate_reg)
            begin
              best_rate_reg <= RSP.rate;
              best_ant_reg  <= scan_ant_reg;
            end
            if (next_ant(scan_ant_reg) == active_reg)
              state_reg <= tsd_pkg::ST_PICK;
            else
            begin
              scan_ant_reg <= next_ant(scan_ant_reg);
              REQ.valid    <= 1'b1;
              REQ.status   <= `TSD_DIV_STAT_SCAN;
              REQ.antenna  <= next_ant(scan_ant_reg);
              ACTIVE_ANT   <= next_ant(scan_ant_reg);
            end
          end
          else if (rsp_late)
          begin
            // Partial scan dropped; stay on the antenna in service
            ACTIVE_ANT <= active_reg;
            state_reg  <= tsd_pkg::ST_RUN;
          end
        end
        tsd_pkg::ST_PICK:
        begin
          active_reg <= best_ant_reg;
          ACTIVE_ANT <= best_ant_reg;
          state_reg  <= tsd_pkg::ST_RUN;
        end
        default: state_reg <= tsd_pkg::ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> src/tsd_pkg.sv
// Purpose: types for the transmit switched diversity controller
// Assumes: tsd_consts.svh supplies widths
// Notes:   commands travel as packed structs
`include "tsd_consts.svh"
`default_nettype none
package tsd_pkg;
  typedef logic [`TSD_ANT_W-1:0] tsd_ant_t;
  // Outgoing diversity setup request
  typedef struct packed {
    logic     valid;
    logic [1:0] status;
    tsd_ant_t antenna;
  } tsd_req_t;
  // Incoming diversity setup response
  typedef struct packed {
    logic       valid;
    logic       capable;
    logic [7:0] rate;
  } tsd_rsp_t;
  // Incoming switch command
  typedef struct packed {
    logic valid;
    logic do_switch;
  } tsd_sw_t;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_RUN   = 5'h04,
    ST_SCAN  = 5'h08,
    ST_PICK  = 5'h10
  } tsd_state_t;
endpackage
`default_nettype wire

// >>> testbench/tb_tsd_ctrl.sv
// Purpose: self-checking bench for the diversity controller
// Assumes: 100 MHz clock, peer model on the far side
// Notes:   period cut to 20 cycles so rescans come quickly
`include "tsd_consts.svh"
`default_nettype none
module tb_tsd_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, rst, rd, wr, busy, frx, wrq;
  logic [5:0]        addr;
  logic [31:0]       wdata, rdata, q;
  logic [7:0]        snr, cur;
  logic [3:0]        dly;
  tsd_pkg::tsd_rsp_t rsp;
  tsd_pkg::tsd_sw_t  sw;
  tsd_pkg::tsd_req_t req;
  tsd_pkg::tsd_ant_t ant;
  int                fails, n_tests, nscan;
  tsd_ctrl dut (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wrq), .TX_BUSY(busy), .CUR_RATE(cur), .RSP(rsp),
    .SW_CMD(sw), .REQ(req), .ACTIVE_ANT(ant));
  tsd_peer_model peer (.clk, .rst, .req, .dly, .rates(32'h30502018),
    .frame_rx(frx), .snr, .rsp, .sw);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Hold the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wrq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic frame(input logic [7:0] s);
    @(posedge clk);
    snr <= s;
    frx <= 1'b1;
    @(posedge clk);
    frx <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  // Count scan probes; non-blocking so readers see a settled count
  always @(posedge clk)
    if (req.valid && req.status == `TSD_DIV_STAT_SCAN) nscan <= nscan + 1;
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    report_and_stop;
  end
  initial
  begin
    {clk, rd, wr, frx, addr, wdata, snr, fails, n_tests, nscan} = '0;
    {rst, busy, dly, cur} = {1'b1, 1'b1, 4'h1, 8'h80};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(`TSD_OFS_PERIOD, `TSD_PERIOD_RST);
    rdchk(`TSD_OFS_RATE_THR, {24'h0, `TSD_RATE_THR_RST});
    rdchk(6'h3C, 32'h0);
    $display("test reset done");
    bus(1'b1, `TSD_OFS_ACTIVE, 32'h2);
    rdchk(`TSD_OFS_ACTIVE, 32'h2);
    bus(1'b1, `TSD_OFS_PERIOD, 32'h14);
    bus(1'b1, `TSD_OFS_CTRL, 32'h5);
    for (int i = 0; i < 50 && req.valid !== 1'b1; i++) @(posedge clk);
    chk({28'h0, req.status, req.antenna}, 32'h6);
    for (int i = 0; i < 50 && rsp.valid !== 1'b1; i++) @(posedge clk);
    rdchk(`TSD_OFS_STATUS, {26'h0, 1'b1, tsd_pkg::ST_RUN});
    rdchk(`TSD_OFS_CTRL, 32'h1);
    frame(8'h80);
    chk({30'h0, ant}, 32'h2);
    frame(8'h10);
    chk({30'h0, ant}, 32'h3);
    frame(8'h10);
    chk({30'h0, ant}, 32'h0);
    $display("test reactive done");
    bus(1'b1, `TSD_OFS_CTRL, 32'h3);
    {dly, cur} <= {4'h4, 8'h08};
    repeat (40) @(posedge clk);
    chk(32'(nscan), 32'h0);
    busy <= 1'b0;
    for (int i = 0; i < 300 && nscan != 3; i++) @(posedge clk);
    chk(32'(nscan), 32'h3);
    for (int i = 0; i < 30 && ant !== 2'h2; i++) @(posedge clk);
    chk({30'h0, ant}, 32'h2);
    rdchk(6'h28, 32'h50);
    for (int i = 0; i < 300 && nscan < 4; i++) @(posedge clk);
    chk(32'(nscan >= 4), 32'h1);
    $display("test proactive done");
    report_and_stop;
  end
endmodule
`default_nettype wire

// >>> testbench/tsd_ctrl_assertions.sv
// Purpose: port checks for the diversity controller
// Assumes: peer answers a request after at least one cycle
// Notes:   run_q marks the reactive run phase only
`include "tsd_consts.svh"
`default_nettype none
module tsd_ctrl_assertions
(
  input wire logic              CLK,
  input wire logic              SYS_RST,
  input wire logic [5:0]        AVS_ADDRESS,
  input wire logic              AVS_READ,
  input wire logic              AVS_WRITE,
  input wire logic [31:0]       AVS_WRITEDATA,
  input wire logic [31:0]       AVS_READDATA,
  input wire logic              AVS_WAITREQUEST,
  input wire logic              TX_BUSY,
  input wire logic [7:0]        CUR_RATE,
  input wire tsd_pkg::tsd_rsp_t RSP,
  input wire tsd_pkg::tsd_sw_t  SW_CMD,
  input wire tsd_pkg::tsd_req_t REQ,
  input wire tsd_pkg::tsd_ant_t ACTIVE_ANT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run_q;
  logic beg_q;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // Run phase: a begin request answered capable, left at any request
  always_ff @(posedge CLK)
  begin
    if (SYS_RST || REQ.valid)
      run_q <= 1'b0;
    else if (RSP.valid && RSP.capable && beg_q)
      run_q <= 1'b1;
  end
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      beg_q <= 1'b0;
    else if (REQ.valid)
      beg_q <= REQ.status == `TSD_DIV_STAT_BEGIN;
  end
  sequence s_switch;
    SW_CMD.valid && SW_CMD.do_switch && run_q;
  endsequence
  sequence s_scan_req;
    REQ.valid && REQ.status == `TSD_DIV_STAT_SCAN;
  endsequence
  a_req_spacing: assert property (REQ.valid |=> !REQ.valid [*2])
    else $error("requests too close");
  a_req_antenna: assert property (
    REQ.valid |-> REQ.antenna == ACTIVE_ANT)
    else $error("request on wrong antenna");
  a_req_status: assert property (REQ.valid |-> REQ.status inside
    {`TSD_DIV_STAT_BEGIN, `TSD_DIV_STAT_SCAN}) else $error("bad status");
  a_switch_moves: assert property (s_switch |=>
    ACTIVE_ANT == $past(ACTIVE_ANT) + 2'h1) else $error("no switch");
  a_active_steady: assert property (run_q && TX_BUSY && !SW_CMD.valid
    |=> $stable(ACTIVE_ANT)) else $error("antenna moved unasked");
  a_scan_idle: assert property (TX_BUSY [*3] |=>
    !(REQ.valid && REQ.status == `TSD_DIV_STAT_SCAN)) else $error("busy scan");
  a_wait_answer: assert property ($rose(AVS_READ || AVS_WRITE)
    |=> !AVS_WAITREQUEST) else $error("late bus answer");
  a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("long bus answer");
  c_scan: cover property (s_scan_req);
endmodule
bind tsd_ctrl tsd_ctrl_assertions u_chk (.CLK, .SYS_RST, .AVS_ADDRESS,
  .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST,
  .TX_BUSY, .CUR_RATE, .RSP, .SW_CMD, .REQ, .ACTIVE_ANT);
`default_nettype wire

// >>> testbench/tsd_peer_model.sv
// Purpose: destination peer for the diversity controller
// Assumes: answers each request dly+1 cycles later, dly at least 1
// Notes:   rate field scrambles while no answer is valid
`default_nettype none
module tsd_peer_model
#(parameter logic [7:0] THR = 8'h40)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire tsd_pkg::tsd_req_t req,
  input  wire logic [3:0]        dly,
  input  wire logic [31:0]       rates,
  input  wire logic              frame_rx,
  input  wire logic [7:0]        snr,
  output tsd_pkg::tsd_rsp_t      rsp,
  output tsd_pkg::tsd_sw_t       sw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  logic [1:0] ant;
  // Answer every request, always capable, with the probed rate
  always_ff @(posedge clk)
  begin
    rsp <= '{1'b0, 1'b0, ~rsp.rate};
    if (rst)
      rsp <= '0;
    else if (cnt == 4'h1)
      rsp <= '{1'b1, 1'b1, rates[{ant, 3'b000} +: 8]};
    if (rst)
      cnt <= 4'h0;
    else if (req.valid)
      cnt <= dly;
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    if (req.valid)
      ant <= req.antenna;
  end
  // Low SNR after a frame asks for a switch
  always_ff @(posedge clk)
    sw <= '{frame_rx, frame_rx && snr < THR};
endmodule
`default_nettype wire
